// >>> include/can_irq_pkg.sv
package can_irq_pkg;

  // Register bus geometry
  localparam int ADDR_W = 3;
  localparam int DATA_W = 16;

  // Register indices on the plain register port
  localparam logic [ADDR_W-1:0] OFS_VEC = 3'h0;
  localparam logic [ADDR_W-1:0] OFS_FCTRL = 3'h1;
  localparam logic [ADDR_W-1:0] OFS_FIFO = 3'h2;
  localparam logic [ADDR_W-1:0] OFS_INTF = 3'h3;
  localparam logic [ADDR_W-1:0] OFS_INTE = 3'h4;

  // Interrupt flag / enable bit positions
  localparam int FLAG_W = 8;
  localparam int BIT_TXBUF = 0;
  localparam int BIT_RXBUF = 1;
  localparam int BIT_OVF = 2;
  localparam int BIT_FIFO = 3;
  localparam int BIT_ERR = 5;
  localparam int BIT_WAKE = 6;
  localparam int BIT_IVR = 7;
  localparam logic [FLAG_W-1:0] FLAG_MASK = 8'hef;
  localparam logic [FLAG_W-1:0] FLAG_RST = 8'h00;

  // Error state field, bits 13..8 of the flag register
  localparam int ERR_W = 6;
  localparam int ERR_LSB = 8;
  localparam int ERR_ANYWARN = 0;
  localparam int ERR_RXWARN = 1;
  localparam int ERR_TXWARN = 2;
  localparam int ERR_RXPASS = 3;
  localparam int ERR_TXPASS = 4;
  localparam int ERR_TXOFF = 5;

  // Interrupt code / filter hit register layout
  localparam int CODE_W = 7;
  localparam int FILT_W = 5;
  localparam int FILT_LSB = 8;
  localparam logic [CODE_W-1:0] CODE_NONE = 7'h40;
  localparam logic [CODE_W-1:0] CODE_ERR = 7'h41;
  localparam logic [CODE_W-1:0] CODE_WAKE = 7'h42;
  localparam logic [CODE_W-1:0] CODE_OVF = 7'h43;
  localparam logic [CODE_W-1:0] CODE_FIFO = 7'h44;
  localparam logic [FILT_W-1:0] FILT_RST = 5'h00;

  // FIFO control layout
  localparam int SIZE_W = 3;
  localparam int SIZE_LSB = 13;
  localparam int START_W = 5;
  localparam logic [SIZE_W-1:0] SIZE_RST = 3'h0;
  localparam logic [START_W-1:0] START_RST = 5'h00;

  // FIFO status layout
  localparam int PTR_W = 6;
  localparam int WPTR_LSB = 8;
  localparam int CNT_W = 6;

  // Buffer index widths
  localparam int TXIDX_W = 3;
  localparam int RXIDX_W = 4;

  // Number of message buffers selected by the size field
  function automatic logic [CNT_W-1:0] buf_count(input logic [SIZE_W-1:0] sel);
    case (sel)
      3'h0: buf_count = 6'h04;
      3'h1: buf_count = 6'h06;
      3'h2: buf_count = 6'h08;
      3'h3: buf_count = 6'h0c;
      3'h4: buf_count = 6'h10;
      3'h5: buf_count = 6'h18;
      3'h6: buf_count = 6'h20;
      default: buf_count = 6'h00;
    endcase
  endfunction

endpackage

// >>> hdl/can_irq_fifo_status_regs.sv
// Added by the designer: the placing of the registers and the plain strobed port.
`timescale 1ns/100ps
// Notes on behaviour
// - Five-bit filter hit number, filters 0..15
// - Fixed codes for fifo, overflow, wake, error, none
// - Buffer interrupt code equals buffer index
// - Three-bit size field picks DMA buffer count
// - Five-bit writable FIFO start buffer
// - Read-only FIFO write buffer pointer
// - Read-only FIFO next read pointer
// - Bit 13 shows transmitter bus-off
// - Bit 12 shows transmitter error-passive
// - Bit 11 shows receiver error-passive
// - Bit 10 shows transmitter error-warning
// - Bit 9 shows receiver error-warning
// - Bit 8 shows any error-warning
// - Error flag raised by error state entries
// - Invalid message sets bit 7 flag
// - Bus wake-up activity sets bit 6 flag
// - FIFO almost full sets bit 3 flag
// - Receive buffer overflow sets bit 2 flag
// - Receive sets bit 1, transmit sets bit 0
// - Enable register per flag, resets to zero
// - Unimplemented bits read as zero
// - Wake-up still sets while disabled; flags kept
module can_irq_fifo_status_regs
  import can_irq_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [ADDR_W-1:0] reg_addr,
  input wire logic [DATA_W-1:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [DATA_W-1:0] reg_rdata,
  input wire logic module_disabled,
  input wire logic ev_invalid_msg,
  input wire logic ev_wakeup,
  input wire logic ev_fifo_almost_full,
  input wire logic ev_rx_overflow,
  input wire logic ev_rx_buffer,
  input wire logic [RXIDX_W-1:0] rx_buffer_index,
  input wire logic [RXIDX_W-1:0] rx_filter_hit,
  input wire logic ev_tx_buffer,
  input wire logic [TXIDX_W-1:0] tx_buffer_index,
  input wire logic tx_bus_off_state,
  input wire logic tx_error_passive_state,
  input wire logic rx_error_passive_state,
  input wire logic tx_warning_state,
  input wire logic rx_warning_state,
  input wire logic [PTR_W-1:0] fifo_write_pointer,
  input wire logic [PTR_W-1:0] fifo_next_read_pointer,
  output logic [SIZE_W-1:0] dma_buffer_count_select,
  output logic [CNT_W-1:0] dma_buffer_count,
  output logic [START_W-1:0] fifo_start_buffer,
  output logic irq,
  output logic [CODE_W-1:0] pending_interrupt_code,
  output logic [FILT_W-1:0] matched_filter_number
);

  logic [FLAG_W-1:0] flags_q;
  logic [FLAG_W-1:0] flags_d;
  logic [FLAG_W-1:0] ev_set;
  logic [FLAG_W-1:0] sw_clr;
  logic [FLAG_W-1:0] en_q;
  logic [FLAG_W-1:0] pend;
  logic [ERR_W-1:0] err_in;
  logic [ERR_W-1:0] err_q;
  logic err_rise;
  logic [SIZE_W-1:0] size_q;
  logic [START_W-1:0] start_q;
  logic [PTR_W-1:0] wptr_q;
  logic [PTR_W-1:0] rptr_q;
  logic [TXIDX_W-1:0] tx_idx_q;
  logic [RXIDX_W-1:0] rx_idx_q;
  logic [RXIDX_W-1:0] filt_hit_q;
  logic [CODE_W-1:0] code_d;
  logic [CODE_W-1:0] code_q;
  logic [FILT_W-1:0] filt_d;
  logic [FILT_W-1:0] filt_q;
  logic irq_q;
  logic [DATA_W-1:0] rdata_q;
  logic wr_intf;
  logic wr_inte;
  logic wr_fctrl;

  // Address decode for writes
  assign wr_intf = reg_wr && (reg_addr == OFS_INTF);
  assign wr_inte = reg_wr && (reg_addr == OFS_INTE);
  assign wr_fctrl = reg_wr && (reg_addr == OFS_FCTRL);

  // Live error state; the any-warning bit is the OR of the two warnings
  always_comb begin
    err_in = '0;
    err_in[ERR_TXOFF] = tx_bus_off_state;
    err_in[ERR_TXPASS] = tx_error_passive_state;
    err_in[ERR_RXPASS] = rx_error_passive_state;
    err_in[ERR_TXWARN] = tx_warning_state;
    err_in[ERR_RXWARN] = rx_warning_state;
    err_in[ERR_ANYWARN] = tx_warning_state | rx_warning_state;
  end

  // Registered error state, shown in the flag register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      err_q <= '0;
    end else begin
      err_q <= err_in;
    end
  end

  // Any newly entered error state raises the error flag
  assign err_rise = |(err_in & ~err_q);

  // Event sources; while disabled only wake-up activity gets through
  always_comb begin
    ev_set = '0;
    ev_set[BIT_IVR] = ev_invalid_msg && !module_disabled;
    ev_set[BIT_WAKE] = ev_wakeup;
    ev_set[BIT_ERR] = err_rise && !module_disabled;
    ev_set[BIT_FIFO] = ev_fifo_almost_full && !module_disabled;
    ev_set[BIT_OVF] = ev_rx_overflow && !module_disabled;
    ev_set[BIT_RXBUF] = ev_rx_buffer && !module_disabled;
    ev_set[BIT_TXBUF] = ev_tx_buffer && !module_disabled;
  end

  // Writing a zero clears a flag; writing a one leaves it alone
  assign sw_clr = wr_intf ? ~reg_wdata[FLAG_W-1:0] : '0;

  // Per-flag next state: a set in the clearing cycle wins over the clear
  genvar gi;
  generate
    for (gi = 0; gi < FLAG_W; gi++) begin : g_flag
      if (FLAG_MASK[gi]) begin : g_impl
        assign flags_d[gi] = ev_set[gi] | (flags_q[gi] & ~sw_clr[gi]);
      end else begin : g_unimpl
        assign flags_d[gi] = 1'b0;
      end
    end
  endgenerate

  // Flag storage; held through disable mode since only sources are gated
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      flags_q <= FLAG_RST;
    end else begin
      flags_q <= flags_d;
    end
  end

  // Interrupt enable register
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      en_q <= FLAG_RST;
    end else if (wr_inte) begin
      en_q <= reg_wdata[FLAG_W-1:0] & FLAG_MASK;
    end
  end

  assign pend = flags_q & en_q;

  // FIFO area control; reserved size code is stored as written
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      size_q <= SIZE_RST;
      start_q <= START_RST;
    end else if (wr_fctrl) begin
      size_q <= reg_wdata[SIZE_LSB +: SIZE_W];
      start_q <= reg_wdata[START_W-1:0];
    end
  end

  assign dma_buffer_count_select = size_q;
  assign dma_buffer_count = buf_count(size_q);
  assign fifo_start_buffer = start_q;

  // Pointer snapshot so reads see a stable registered value
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      wptr_q <= '0;
      rptr_q <= '0;
    end else begin
      wptr_q <= fifo_write_pointer;
      rptr_q <= fifo_next_read_pointer;
    end
  end

  // Remember the last buffer and filter of each buffer event
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      tx_idx_q <= '0;
      rx_idx_q <= '0;
      filt_hit_q <= '0;
    end else begin
      if (ev_set[BIT_TXBUF]) begin
        tx_idx_q <= tx_buffer_index;
      end
      if (ev_set[BIT_RXBUF]) begin
        rx_idx_q <= rx_buffer_index;
        filt_hit_q <= rx_filter_hit;
      end
    end
  end

  // Priority encoder: error first, buffer events last
  always_comb begin
    code_d = CODE_NONE;
    filt_d = FILT_RST;
    if (pend[BIT_ERR]) begin
      code_d = CODE_ERR;
    end else if (pend[BIT_WAKE]) begin
      code_d = CODE_WAKE;
    end else if (pend[BIT_OVF]) begin
      code_d = CODE_OVF;
    end else if (pend[BIT_FIFO]) begin
      code_d = CODE_FIFO;
    end else if (pend[BIT_TXBUF]) begin
      code_d = CODE_W'(tx_idx_q);
    end else if (pend[BIT_RXBUF]) begin
      code_d = CODE_W'(rx_idx_q);
      filt_d = FILT_W'(filt_hit_q);
    end
  end

  // Code, filter and request are registered to keep outputs glitch free
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      code_q <= CODE_NONE;
      filt_q <= FILT_RST;
      irq_q <= 1'b0;
    end else begin
      code_q <= code_d;
      filt_q <= filt_d;
      irq_q <= |pend;
    end
  end

  assign pending_interrupt_code = code_q;
  assign matched_filter_number = filt_q;
  assign irq = irq_q;

  // Read mux; unmapped indices and unused bits read as zero
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      rdata_q <= '0;
    end else if (reg_rd) begin
      rdata_q <= '0;
      case (reg_addr)
        OFS_VEC: begin
          rdata_q[FILT_LSB +: FILT_W] <= filt_q;
          rdata_q[CODE_W-1:0] <= code_q;
        end
        OFS_FCTRL: begin
          rdata_q[SIZE_LSB +: SIZE_W] <= size_q;
          rdata_q[START_W-1:0] <= start_q;
        end
        OFS_FIFO: begin
          rdata_q[WPTR_LSB +: PTR_W] <= wptr_q;
          rdata_q[PTR_W-1:0] <= rptr_q;
        end
        OFS_INTF: begin
          rdata_q[ERR_LSB +: ERR_W] <= err_q;
          rdata_q[FLAG_W-1:0] <= flags_q;
        end
        OFS_INTE: begin
          rdata_q[FLAG_W-1:0] <= en_q;
        end
        default: begin
          rdata_q <= '0;
        end
      endcase
    end else begin
      rdata_q <= '0;
    end
  end

  assign reg_rdata = rdata_q;

  // Checks
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);

  sequence s_clear_all_intf;
    wr_intf && (reg_wdata[FLAG_W-1:0] == 8'h00);
  endsequence

  sequence s_write_fctrl;
    wr_fctrl ##1 (reg_rd && reg_addr == OFS_FCTRL);
  endsequence

  a_flag_no_sw_set: assert property (
    (wr_intf && reg_wdata[BIT_IVR] && !flags_q[BIT_IVR] && !ev_set[BIT_IVR])
    |=> !flags_q[BIT_IVR])
    else $error("software write set a flag");

  a_wake_when_disabled: assert property (
    ev_wakeup |=> flags_q[BIT_WAKE])
    else $error("wake-up event did not set its flag");

  a_set_beats_clear: assert property (
    (ev_invalid_msg && !module_disabled) and s_clear_all_intf |=> flags_q[BIT_IVR])
    else $error("invalid message lost against clear");

  a_err_edge_flag: assert property (
    ($rose(tx_bus_off_state) && !module_disabled && $stable(err_in[ERR_TXWARN]))
    |=> flags_q[BIT_ERR])
    else $error("error state entry did not raise flag");

  a_warn_or_read: assert property (
    (reg_rd && reg_addr == OFS_INTF)
    |=> reg_rdata[ERR_LSB] == (reg_rdata[ERR_LSB+1] | reg_rdata[ERR_LSB+2]))
    else $error("any-warning bit disagrees with warnings");

  a_code_idle: assert property (
    (pend == '0) [*2] |=> (code_q == CODE_NONE) && !irq)
    else $error("code not idle with nothing pending");

  a_irq_tracks: assert property (
    (flags_q[BIT_FIFO] && en_q[BIT_FIFO]) |=> irq)
    else $error("request missing for enabled flag");

  a_vec_zero_bits: assert property (
    (reg_rd && reg_addr == OFS_VEC)
    |=> (reg_rdata[15:13] == 3'h0) && !reg_rdata[7])
    else $error("unimplemented vector bits not zero");

  a_fctrl_back: assert property (
    s_write_fctrl |=> reg_rdata[START_W-1:0] == $past(reg_wdata[START_W-1:0], 2))
    else $error("fifo start buffer readback wrong");

  a_ptr_read: assert property (
    (reg_rd && reg_addr == OFS_FIFO)
    |=> reg_rdata[WPTR_LSB +: PTR_W] == $past(fifo_write_pointer, 2))
    else $error("write pointer readback wrong");

  a_wake_code: assert property (
    (pend == 8'h40) |=> code_q == CODE_WAKE)
    else $error("wake-up code wrong");

  a_tx_code: assert property (
    (pend == 8'h01) |=> code_q == {4'h0, $past(tx_idx_q)})
    else $error("transmit buffer code wrong");

  a_reset_code: assert property (
    $rose(rst_b) |-> code_q == CODE_NONE)
    else $error("code not idle after reset");

  a_disabled_gate: assert property (
    (module_disabled && ev_fifo_almost_full && !flags_q[BIT_FIFO])
    |=> !flags_q[BIT_FIFO])
    else $error("event set a flag while disabled");

  a_rx_filter_code: assert property (
    (pend == 8'h02)
    |=> (matched_filter_number == FILT_W'($past(filt_hit_q)))
      && (pending_interrupt_code == CODE_W'($past(rx_idx_q))))
    else $error("receive code or filter number wrong");

  // Error image lags the pins by two edges: one in err_q, one in the read register
  a_err_image: assert property (
    (reg_rd && reg_addr == OFS_INTF)
    |=> (reg_rdata[ERR_LSB+ERR_TXOFF] == $past(tx_bus_off_state, 2))
      && (reg_rdata[ERR_LSB+ERR_RXPASS] == $past(rx_error_passive_state, 2)))
    else $error("error state image wrong");

  // Read data stands one cycle only, so a stale word cannot be taken twice
  a_rdata_idle: assert property (
    !reg_rd |=> (reg_rdata == '0))
    else $error("read data not zero outside a read");

endmodule // can_irq_fifo_status_regs

// >>> sim/can_node_model.sv
`timescale 1ns/100ps
// Protocol side of the block: turns one-cycle bench requests into event
// pulses and holds the error-state levels, as the bus engine would
module can_node_model (
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic [7:0] ev_req,
  input wire logic [3:0] idx_req,
  input wire logic [3:0] filt_req,
  input wire logic [4:0] err_req,
  output logic [7:0] ev_q,
  output logic [3:0] idx_out,
  output logic [3:0] filt_out,
  output logic [4:0] err_q
);
  logic [3:0] idx_q;
  logic [3:0] filt_q;

  // Pulses last exactly one cycle because the requests do
  always_ff @(posedge sys_clk or negedge rst_b) begin
    if (!rst_b) begin
      ev_q <= 8'h00;
      idx_q <= 4'h0;
      filt_q <= 4'h0;
      err_q <= 5'h00;
    end else begin
      ev_q <= ev_req;
      idx_q <= idx_req;
      filt_q <= filt_req;
      err_q <= err_req;
    end
  end

  // Index lines mean nothing outside a pulse; show the inverse, not a stale value
  assign idx_out = (ev_q[0] | ev_q[1]) ? idx_q : ~idx_q;
  assign filt_out = ev_q[1] ? filt_q : ~filt_q;
endmodule // can_node_model

// >>> sim/can_irq_fifo_status_regs_tb.sv
`timescale 1ns/100ps
module can_irq_fifo_status_regs_tb;
  import can_irq_pkg::*;
  logic sys_clk = 1'b0;
  logic rst_b = 1'b0;
  logic [ADDR_W-1:0] reg_addr = 3'h0;
  logic [DATA_W-1:0] reg_wdata = 16'h0000;
  logic reg_wr = 1'b0;
  logic reg_rd = 1'b0;
  logic module_disabled = 1'b0;
  logic [7:0] ev_req = 8'h00;
  logic [3:0] idx_req = 4'h0;
  logic [3:0] filt_req = 4'h0;
  logic [4:0] err_req = 5'h00;
  logic [PTR_W-1:0] wptr = 6'h00;
  logic [PTR_W-1:0] rptr = 6'h00;
  logic [7:0] ev;
  logic [3:0] idx;
  logic [3:0] filt;
  logic [4:0] err;
  logic [DATA_W-1:0] reg_rdata;
  logic [SIZE_W-1:0] size_sel;
  logic [CNT_W-1:0] buf_cnt;
  logic [START_W-1:0] start_buf;
  logic irq;
  logic [CODE_W-1:0] code;
  logic [FILT_W-1:0] filt_num;
  logic [DATA_W-1:0] seen;
  int n_fail = 0;
  int comparisons = 0;
  int cycles = 0;
  logic [CNT_W-1:0] cnt_tab [8] = '{6'h04, 6'h06, 6'h08, 6'h0c, 6'h10, 6'h18, 6'h20, 6'h00};
  int pos_tab [6] = '{7, 6, 2, 3, 0, 1};
  logic [15:0] vec_tab [6] = '{16'h0040, 16'h0042, 16'h0043, 16'h0044, 16'h0007, 16'h090f};

  // Clock, 10 ns period
  always #5 sys_clk = ~sys_clk;

  can_node_model node_u (.sys_clk(sys_clk), .rst_b(rst_b), .ev_req(ev_req), .idx_req(idx_req),
    .filt_req(filt_req), .err_req(err_req), .ev_q(ev), .idx_out(idx), .filt_out(filt),
    .err_q(err));

  can_irq_fifo_status_regs dut_u (.sys_clk(sys_clk), .rst_b(rst_b), .reg_addr(reg_addr),
    .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .module_disabled(module_disabled), .ev_invalid_msg(ev[7]), .ev_wakeup(ev[6]),
    .ev_fifo_almost_full(ev[3]), .ev_rx_overflow(ev[2]), .ev_rx_buffer(ev[1]),
    .rx_buffer_index(idx), .rx_filter_hit(filt), .ev_tx_buffer(ev[0]),
    .tx_buffer_index(idx[2:0]), .tx_bus_off_state(err[4]), .tx_error_passive_state(err[3]),
    .rx_error_passive_state(err[2]), .tx_warning_state(err[1]), .rx_warning_state(err[0]),
    .fifo_write_pointer(wptr), .fifo_next_read_pointer(rptr), .dma_buffer_count_select(size_sel),
    .dma_buffer_count(buf_cnt), .fifo_start_buffer(start_buf), .irq(irq),
    .pending_interrupt_code(code), .matched_filter_number(filt_num));

  task automatic close_out();
    $display("comparisons %0d mismatches %0d", comparisons, n_fail);
    if (n_fail == 0 && comparisons > 0)
      $display("bench passed");
    else
      $display("bench failed");
    $finish;
  endtask

  task automatic chk(input string what, input logic [15:0] s, input logic [15:0] e);
    comparisons++;
    if (s !== e) begin
      n_fail++;
      $display("MISMATCH %s expected %h seen %h", what, e, s);
    end
  endtask

  // Bus cycles: strobe for one cycle, settle one step past the edge before returning
  task automatic wr(input logic [2:0] a, input logic [15:0] d);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    #1;
  endtask

  task automatic rc(input string what, input logic [2:0] a, input logic [15:0] e);
    @(posedge sys_clk);
    reg_rd <= 1'b1;
    reg_addr <= a;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 seen = reg_rdata;
    chk(what, seen, e);
  endtask

  // Write then read straight after it, with no idle cycle between the strobes
  task automatic wr_rc(input string what, input logic [2:0] a, input logic [15:0] d,
    input logic [15:0] e);
    @(posedge sys_clk);
    reg_wr <= 1'b1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge sys_clk);
    reg_wr <= 1'b0;
    reg_rd <= 1'b1;
    @(posedge sys_clk);
    reg_rd <= 1'b0;
    #1 seen = reg_rdata;
    chk(what, seen, e);
  endtask

  task automatic fire(input logic [7:0] m);
    @(posedge sys_clk);
    ev_req <= m;
    @(posedge sys_clk);
    ev_req <= 8'h00;
    repeat (3) @(posedge sys_clk);
  endtask

  // Hang guard, well beyond the few hundred cycles the tests need
  always @(posedge sys_clk) begin
    cycles++;
    if (cycles == 3000) begin
      n_fail++;
      $display("timeout");
      close_out();
    end
  end

  initial begin
    repeat (6) @(posedge sys_clk);
    rst_b <= 1'b1;
    idx_req <= 4'hf;
    filt_req <= 4'h9;
    rc("vec", OFS_VEC, 16'h0040);
    rc("fctrl", OFS_FCTRL, 16'h0000);
    rc("flags", OFS_INTF, 16'h0000);
    rc("enables", OFS_INTE, 16'h0000);
    chk("irq", {15'h0000, irq}, 16'h0000);
    $display("test reset done");
    wr_rc("fctrl", OFS_FCTRL, 16'hffff, 16'he01f);
    chk("start", {11'h000, start_buf}, 16'h001f);
    for (int i = 0; i < 8; i++) begin
      wr(OFS_FCTRL, {i[2:0], 13'h0000});
      chk("size", {7'h00, size_sel, buf_cnt}, {7'h00, i[2:0], cnt_tab[i]});
    end
    wr(3'h5, 16'hffff);
    rc("unmapped", 3'h5, 16'h0000);
    wr(OFS_VEC, 16'hffff);
    rc("vec", OFS_VEC, 16'h0040);
    @(posedge sys_clk);
    wptr <= 6'h1f;
    rptr <= 6'h15;
    wr(OFS_FIFO, 16'hffff);
    rc("fifo", OFS_FIFO, 16'h1f15);
    wr(OFS_INTE, 16'hffff);
    rc("enables", OFS_INTE, 16'h00ef);
    $display("test registers done");
    // Each event source except error on its own: flag, code, request, clear-only behaviour
    for (int i = 0; i < 6; i++) begin
      fire(8'h01 << pos_tab[i]);
      rc("flags", OFS_INTF, 16'h0001 << pos_tab[i]);
      rc("vec", OFS_VEC, vec_tab[i]);
      chk("irq", {15'h0000, irq}, 16'h0001);
      chk("code port", {3'h0, filt_num, 1'b0, code}, vec_tab[i]);
      wr(OFS_INTF, 16'hffff);
      rc("kept", OFS_INTF, 16'h0001 << pos_tab[i]);
      wr(OFS_INTF, 16'h0000);
      rc("vec", OFS_VEC, 16'h0040);
    end
    // Wake-up outranks a transmit event until its enable is dropped
    fire(8'h41);
    rc("vec", OFS_VEC, 16'h0042);
    wr(OFS_INTE, 16'h0001);
    rc("vec", OFS_VEC, 16'h0007);
    wr(OFS_INTE, 16'h0000);
    rc("vec", OFS_VEC, 16'h0040);
    chk("irq", {15'h0000, irq}, 16'h0000);
    wr(OFS_INTF, 16'h0000);
    wr(OFS_INTE, 16'hffff);
    $display("test events done");
    // One error state at a time; entry raises the error flag
    for (int i = 0; i < 5; i++) begin
      @(posedge sys_clk);
      err_req <= 5'h01 << i;
      repeat (4) @(posedge sys_clk);
      rc("errstate", OFS_INTF, {2'b00, 5'h01 << i, i < 2, 8'h20});
      rc("vec", OFS_VEC, 16'h0041);
      @(posedge sys_clk);
      err_req <= 5'h00;
      wr(OFS_INTF, 16'h0000);
    end
    $display("test error states done");
    // Invalid message in the same cycle as a clear-all write: the set wins
    fork
      fire(8'h80);
      begin
        @(posedge sys_clk);
        wr(OFS_INTF, 16'h0000);
      end
    join
    rc("setwins", OFS_INTF, 16'h0080);
    wr(OFS_INTF, 16'h0000);
    // Disabled: only wake-up sets, and the flag survives re-enable
    @(posedge sys_clk);
    module_disabled <= 1'b1;
    fire(8'h44);
    rc("flags", OFS_INTF, 16'h0040);
    @(posedge sys_clk);
    module_disabled <= 1'b0;
    rc("flags", OFS_INTF, 16'h0040);
    $display("test disable done");
    close_out();
  end
endmodule // can_irq_fifo_status_regs_tb
